// File: dv/arb_block_upload_parser_asserts.sv
`timescale 1ns/100ps
// ==========
// Port checks
module parser_asserts
#(
	parameter int CW = 24
)
(
	input wire logic                  SYS_CLK_I,
	input wire logic                  RST_N_I,
	input wire logic                  START_I,
	input wire logic [CW-1:0]         TOTAL_BYTES_I,
	input wire logic                  BYTE_VALID_I,
	input wire upload_pkg::bus_byte_t BYTE_I,
	input wire logic                  BUSY_O,
	input wire logic                  DONE_O,
	input wire logic                  FORMAT_ERR_O,
	input wire logic                  SAMPLE_VALID_O,
	input wire upload_pkg::sample_t   SAMPLE_O
);
	logic [17:0] last_d;
	logic [17:0] last_q;
	always_comb last_d = SAMPLE_VALID_O ? SAMPLE_O.addr : last_q;
	always_ff @(posedge SYS_CLK_I) last_q <= last_d;
	default clocking @(posedge SYS_CLK_I); endclocking
	default disable iff (!RST_N_I);
	sequence take_s(logic [7:0] c);
		BYTE_VALID_I && BYTE_I.data == c;
	endsequence
	sequence go_s;
		START_I && !BUSY_O;
	endsequence
	go_a: assert property (go_s |=> BUSY_O && !FORMAT_ERR_O)
		else $error("start not taken");
	done_pulse_a: assert property (DONE_O |=> !DONE_O)
		else $error("done too long");
	done_idle_a: assert property (DONE_O |-> !BUSY_O)
		else $error("busy at done");
	idle_hold_a: assert property (!BUSY_O && !START_I |=> !BUSY_O)
		else $error("busy without start");
	zero_count_a: assert property (go_s ##1 take_s(8'h23) ##1 take_s(8'h30)
		|-> ##[1:2] FORMAT_ERR_O) else $error("zero digit count accepted");
	walk_two_a: assert property (START_I && !BUSY_O && TOTAL_BYTES_I == 2
		##1 take_s(8'h23) ##1 take_s(8'h31) ##1 take_s(8'h32) ##1 BYTE_VALID_I [*2]
		|-> ##1 (SAMPLE_VALID_O && SAMPLE_O.addr == 0) ##1 DONE_O) else $error("short upload");
	pair_gap_a: assert property (SAMPLE_VALID_O |=> !SAMPLE_VALID_O)
		else $error("sample too long");
	sample_hold_a: assert property (!SAMPLE_VALID_O |-> $stable(SAMPLE_O))
		else $error("sample moved");
	addr_step_a: assert property (SAMPLE_VALID_O && SAMPLE_O.addr != 0
		|-> SAMPLE_O.addr == last_q + 18'h1) else $error("address skip");
endmodule
bind arb_block_upload_parser parser_asserts #(.CW(CW)) parser_asserts_inst (.SYS_CLK_I,
	.RST_N_I, .START_I, .TOTAL_BYTES_I, .BYTE_VALID_I, .BYTE_I, .BUSY_O, .DONE_O,
	.FORMAT_ERR_O, .SAMPLE_VALID_O, .SAMPLE_O);

// File: dv/test_arb_block_upload_parser.sv
`timescale 1ns/100ps
// ==========
// Upload bench
module test_arb_block_upload_parser;
	logic clk = 0;
	logic rst_n = 0;
	logic start = 0;
	logic [23:0] total = 0;
	logic busy, done, err, sval, bv;
	upload_pkg::bus_byte_t bb;
	upload_pkg::sample_t smp;
	int n_errors = 0;
	int n_checks = 0;
	int n_done = 0;
	logic [29:0] exp_q[$];
	always #4 clk = ~clk;
	upload_host upload_host_inst (.clk_i(clk), .byte_o(bb), .valid_o(bv));
	arb_block_upload_parser arb_block_upload_parser_inst (.SYS_CLK_I(clk), .RST_N_I(rst_n),
		.START_I(start), .TOTAL_BYTES_I(total), .BYTE_VALID_I(bv), .BYTE_I(bb),
		.BUSY_O(busy), .DONE_O(done), .FORMAT_ERR_O(err), .SAMPLE_VALID_O(sval),
		.SAMPLE_O(smp));
	task check(logic [31:0] got, logic [31:0] want);
		n_checks++;
		if (got !== want)
		begin
			n_errors++;
			$display("[ERR] %0t got %h exp %h", $time, got, want);
		end
	endtask
	task test_done;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	always @(posedge clk)
	begin
		if (sval === 1'b1)
			check(smp, exp_q.size() ? exp_q.pop_front() : 30'h3FFFFFFF);
		if (done === 1'b1)
			n_done++;
	end
	// Block sizes stay even so a pair never straddles blocks
	task upload(int tot, int bs, int slow, int bad);
		int a;
		int d0;
		logic [7:0] b;
		logic [7:0] lo;
		a = 0;
		d0 = n_done;
		total = tot;
		start = 1;
		@(posedge clk);
		#1;
		start = 0;
		if (bad)
		begin
			upload_host_inst.put(8'h23, 0);
			upload_host_inst.put(8'h30, 0);
			upload_host_inst.put(8'h21, 0);
			upload_host_inst.idle(1);
			check(err, 1);
		end
		while (a < tot)
		begin
			repeat (bs)
			begin
				b = (a % 7 == 3) ? 8'h0A : (a % 7 == 5) ? 8'h23 : 8'($urandom);
				upload_host_inst.pay.push_back(b);
				if (a % 2) exp_q.push_back({18'(a / 2), b, lo[7:4]});
				else lo = b;
				a++;
			end
			upload_host_inst.send_block(bs, slow);
			if (a < tot) upload_host_inst.say(3);
		end
		repeat (4) @(posedge clk);
		#1;
		check(n_done, d0 + 1);
		check(exp_q.size(), 0);
		check({busy, err}, {1'b0, 1'(bad)});
	endtask
	initial
	begin
		void'($urandom(32'h426F));
		repeat (12) @(posedge clk);
		#1 rst_n = 1;
		@(posedge clk);
		#1;
		upload_host_inst.say(8);
		check(busy, 0);
		upload(2, 2, 0, 0);
		upload(16, 4, 0, 1);
		upload(4096, 4096, 1, 0);
		upload(4096, 256, 0, 0);
		upload(64, 16, 1, 0);
		test_done;
	end
	initial
	begin
		#400000;
		n_errors++;
		test_done;
	end
endmodule

// File: dv/upload_host.sv
`timescale 1ns/100ps
// ==========
// Bus controller host
module upload_host
(
	input  wire logic            clk_i,
	output upload_pkg::bus_byte_t byte_o,
	output logic                 valid_o
);
	logic [7:0] pay[$];
	initial
	begin
		valid_o = 0;
		byte_o = '0;
	end
	task put(logic [7:0] d, logic e);
		valid_o = 1;
		byte_o = {d, e};
		@(posedge clk_i);
		#1;
	endtask
	// Released data shows a changed value, never the old one
	task idle(int n);
		valid_o = 0;
		byte_o.data = ~byte_o.data;
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	// Stray text, never a marker or a digit
	task say(int n);
		for (int i = 0; i < n; i++)
			put(8'(8'h41 + i % 26), 0);
		idle(1);
	endtask
	task send_block(int n, int slow);
		string s;
		s.itoa(n);
		put(8'h23, 0);
		put(8'(8'h30 + s.len()), 0);
		for (int i = 0; i < s.len(); i++)
			put(s[i], 0);
		for (int i = 0; i < n; i++)
		begin
			put(pay.pop_front(), (i == n - 1) && slow);
			if (slow) idle(1);
		end
		idle(1);
	endtask
endmodule

// File: include/upload_params.svh
`ifndef UPLOAD_PARAMS_SVH
`define UPLOAD_PARAMS_SVH

`define CHR_BLOCK_MARK 8'h23
`define CHR_DIGIT_0    8'h30
`define CHR_DIGIT_9    8'h39
`define CNT_WIDTH      24
`define MIN_POINTS     24'h000800
`define MAX_POINTS     24'h040000

`endif

// File: include/upload_pkg.sv
package upload_pkg;

	typedef enum logic [5:0] {
		ST_IDLE   = 6'b000001,
		ST_MARK   = 6'b000010,
		ST_NDIG   = 6'b000100,
		ST_COUNT  = 6'b001000,
		ST_DATA   = 6'b010000,
		ST_DONE   = 6'b100000
	} parse_state_t;

	typedef struct packed {
		logic [7:0] data;
		logic       eoi;
	} bus_byte_t;

	typedef struct packed {
		logic [17:0] addr;
		logic [11:0] value;
	} sample_t;

endpackage

// File: verilog/arb_block_upload_parser.sv
`timescale 1ns/100ps
`include "upload_params.svh"

module arb_block_upload_parser
#(
	parameter int CW = `CNT_WIDTH
)
(
	input  wire logic                    SYS_CLK_I,
	input  wire logic                    RST_N_I,
	input  wire logic                    START_I,
	input  wire logic [CW-1:0]           TOTAL_BYTES_I,
	input  wire logic                    BYTE_VALID_I,
	input  wire upload_pkg::bus_byte_t   BYTE_I,
	output logic                         BUSY_O,
	output logic                         DONE_O,
	output logic                         FORMAT_ERR_O,
	output logic                         SAMPLE_VALID_O,
	output upload_pkg::sample_t          SAMPLE_O
);

	// ==========================================
	// Helpers
	function automatic logic is_digit(input logic [7:0] c);
		is_digit = (c >= `CHR_DIGIT_0) && (c <= `CHR_DIGIT_9);
	endfunction

	function automatic logic [3:0] digit_val(input logic [7:0] c);
		digit_val = 4'(c - `CHR_DIGIT_0);
	endfunction

	// Wraps silently beyond CW bits; longer count fields are not guarded
	function automatic logic [CW-1:0] count_step(input logic [CW-1:0] acc,
	                                             input logic [7:0]    ch);
		count_step = CW'(acc * CW'(10) + CW'(digit_val(ch)));
	endfunction

	// ==========================================
	// Parser state
	upload_pkg::parse_state_t st_q, st_d;
	logic [CW-1:0]  total_q,  total_d;
	logic [CW-1:0]  got_q,    got_d;
	logic [CW-1:0]  blk_q,    blk_d;
	logic [CW-1:0]  left_q,   left_d;
	logic [3:0]     ndig_q,   ndig_d;
	logic           done_q,   done_d;
	logic           err_q,    err_d;
	logic           data_stb;
	logic [7:0]     c;
	logic           take_start;

	assign c = BYTE_I.data;

	// ==========================================
	// Command decode
	// A load command is refused while busy; the host must wait for idle
	assign take_start = (st_q == upload_pkg::ST_IDLE) && START_I;

	always_comb
	begin
		st_d     = st_q;
		total_d  = total_q;
		got_d    = got_q;
		blk_d    = blk_q;
		left_d   = left_q;
		ndig_d   = ndig_q;
		done_d   = 1'b0;
		err_d    = err_q;
		data_stb = 1'b0;
		case (st_q)
			upload_pkg::ST_IDLE:
			begin
				if (take_start)
				begin
					total_d = TOTAL_BYTES_I;
					got_d   = '0;
					err_d   = 1'b0;
					// An empty upload finishes at once
					if (TOTAL_BYTES_I == '0)
						st_d = upload_pkg::ST_DONE;
					else
						st_d = upload_pkg::ST_MARK;
				end
			end
			upload_pkg::ST_MARK:
			begin
				// Anything but a marker here is a stray message and is dropped
				if (BYTE_VALID_I && c == `CHR_BLOCK_MARK)
					st_d = upload_pkg::ST_NDIG;
			end
			upload_pkg::ST_NDIG:
			begin
				if (BYTE_VALID_I)
				begin
					if (is_digit(c) && c != `CHR_DIGIT_0)
					begin
						ndig_d = digit_val(c);
						blk_d  = '0;
						st_d   = upload_pkg::ST_COUNT;
					end
					else
					begin
						err_d = 1'b1;
						st_d  = upload_pkg::ST_MARK;
					end
				end
			end
			upload_pkg::ST_COUNT:
			begin
				if (BYTE_VALID_I)
				begin
					if (is_digit(c))
					begin
						// Decimal, most significant digit first
						blk_d  = count_step(blk_q, c);
						ndig_d = ndig_q - 4'h1;
						if (ndig_q == 4'h1)
						begin
							left_d = count_step(blk_q, c);
							// Zero-length block carries nothing, wait for the next one
							if (left_d == '0)
								st_d = upload_pkg::ST_MARK;
							else
								st_d = upload_pkg::ST_DATA;
						end
					end
					else
					begin
						err_d = 1'b1;
						st_d  = upload_pkg::ST_MARK;
					end
				end
			end
			upload_pkg::ST_DATA:
			begin
				// Every byte is payload: line feed and EOI have no meaning here
				if (BYTE_VALID_I)
				begin
					data_stb = 1'b1;
					left_d   = left_q - CW'(1);
					got_d    = got_q + CW'(1);
					// Total wins over block end; the rest of a long block is dropped
					if (got_d == total_q)
						st_d = upload_pkg::ST_DONE;
					else if (left_q == CW'(1))
						st_d = upload_pkg::ST_MARK;
				end
			end
			upload_pkg::ST_DONE:
			begin
				done_d = 1'b1;
				st_d   = upload_pkg::ST_IDLE;
			end
			default:
				st_d = upload_pkg::ST_IDLE;
		endcase
	end

	// ==========================================
	// Registers
	always_ff @(posedge SYS_CLK_I)
	begin
		if (!RST_N_I)
		begin
			st_q    <= upload_pkg::ST_IDLE;
			total_q <= '0;
			got_q   <= '0;
			blk_q   <= '0;
			left_q  <= '0;
			ndig_q  <= 4'h0;
			done_q  <= 1'b0;
			err_q   <= 1'b0;
		end
		else
		begin
			st_q    <= st_d;
			total_q <= total_d;
			got_q   <= got_d;
			blk_q   <= blk_d;
			left_q  <= left_d;
			ndig_q  <= ndig_d;
			done_q  <= done_d;
			err_q   <= err_d;
		end
	end

	// ==========================================
	// Sample assembly
	// Pairing restarts on each upload; odd block sizes would shift it across blocks
	sample_packer sample_packer_inst
	(
		.SYS_CLK_I      (SYS_CLK_I),
		.RST_N_I        (RST_N_I),
		.clear_i        (take_start),
		.byte_valid_i   (data_stb),
		.byte_i         (c),
		.sample_valid_o (SAMPLE_VALID_O),
		.sample_o       (SAMPLE_O)
	);

	// ==========================================
	// Outputs
	assign BUSY_O       = (st_q != upload_pkg::ST_IDLE);
	assign DONE_O       = done_q;
	assign FORMAT_ERR_O = err_q;

endmodule

// File: verilog/sample_packer.sv
`timescale 1ns/100ps
`include "upload_params.svh"

// ==========================================
// Byte pair to 12-bit sample
module sample_packer
(
	input  wire logic                     SYS_CLK_I,
	input  wire logic                     RST_N_I,
	input  wire logic                     clear_i,
	input  wire logic                     byte_valid_i,
	input  wire logic [7:0]               byte_i,
	output logic                          sample_valid_o,
	output upload_pkg::sample_t           sample_o
);

	logic                 half_q,  half_d;
	logic [3:0]           low_q,   low_d;
	logic [17:0]          addr_q,  addr_d;
	logic                 valid_q, valid_d;
	upload_pkg::sample_t  smp_q,   smp_d;

	always_comb
	begin
		half_d  = half_q;
		low_d   = low_q;
		addr_d  = addr_q;
		valid_d = 1'b0;
		smp_d   = smp_q;
		// Only the pairing and the next address restart, so the last sample stays on the output
		if (clear_i)
		begin
			half_d = 1'b0;
			addr_d = 18'h00000;
		end
		else if (byte_valid_i)
		begin
			if (!half_q)
			begin
				low_d  = byte_i[7:4];
				half_d = 1'b1;
			end
			else
			begin
				// Two's complement passes straight through
				smp_d.value = {byte_i, low_q};
				smp_d.addr  = addr_q;
				addr_d      = addr_q + 18'h00001;
				valid_d     = 1'b1;
				half_d      = 1'b0;
			end
		end
	end

	always_ff @(posedge SYS_CLK_I)
	begin
		if (!RST_N_I)
		begin
			half_q  <= 1'b0;
			low_q   <= 4'h0;
			addr_q  <= 18'h00000;
			valid_q <= 1'b0;
			smp_q   <= '0;
		end
		else
		begin
			half_q  <= half_d;
			low_q   <= low_d;
			addr_q  <= addr_d;
			valid_q <= valid_d;
			smp_q   <= smp_d;
		end
	end

	assign sample_valid_o = valid_q;
	assign sample_o       = smp_q;

endmodule
